/* few_pkg.sv */
/*
 fewp package: constants, states and bus layout for the flash emulation and writer port block.
 assumes a 200 MHz core clock and an APB register bus with 32-bit data.
*/
package few_pkg;
	// register byte offsets
	localparam logic [11:0] OFS_EMUL = 12'h000; // ram_emulation_control
	localparam logic [11:0] OFS_FCTL = 12'h004; // flash_control_one
	localparam logic [11:0] OFS_STAT = 12'h008; // writer and lock status
	// field positions
	localparam int EMU_EN_POS = 2; // emulation_enable_bit
	localparam int SEL_HI_POS = 1; // overlay_select_high
	localparam int SEL_LO_POS = 0; // overlay_select_low
	localparam int PROG_POS = 0;
	localparam int ERASE_POS = 1;
	localparam int BOOT_POS = 2;
	localparam int ERRP_POS = 3;
	// reset values
	localparam logic [2:0] EMUL_RST = 3'h0;
	localparam logic [3:0] FCTL_RST = 4'h0;
	// writer commands
	localparam logic [7:0] CMD_READ = 8'h00;
	localparam logic [7:0] CMD_PROG = 8'h40;
	localparam logic [7:0] CMD_ERASE = 8'h20;
	localparam logic [7:0] CMD_STAT = 8'h71;
	// sizes
	localparam int ADDR_W = 17;
	localparam int PAGE_BYTES = 128;
	localparam logic [7:0] PROG_CYCLES = 8'd129;
	localparam logic [1:0] EMUL_BLOCK_ONE = 2'h1;
	// status bits
	localparam int DONE_POS = 6;
	localparam int FAIL_POS = 4;
	// auto operation time
	localparam int OP_TIME_NS = 1000;
	localparam int CLK_NS = 5;
	localparam logic [15:0] OP_CYCLES = 16'(OP_TIME_NS / CLK_NS);
	// writer port states
	typedef enum logic [4:0] {
		WS_READ = 5'b00001,
		WS_WAIT = 5'b00010,
		WS_PROG = 5'b00100,
		WS_BUSY = 5'b01000,
		WS_STAT = 5'b10000
	} few_wstate_t;
endpackage

/* few_sync_if.sv */
/*
 fewp interface between the pin synchroniser and the main block.
 assumes one clock domain.
*/
`timescale 1ns/1ps
interface few_sync_if;
	logic ce_n;
	logic oe_n;
	logic we_n;
	logic flash_write_enable_pin;
	logic mode_ok;
	modport src(output ce_n, oe_n, we_n, flash_write_enable_pin, mode_ok);
	modport dst(input ce_n, oe_n, we_n, flash_write_enable_pin, mode_ok);
endinterface

/* few_pinsync.sv */
/*
 fewp pin synchroniser: three stage flops and an output flop per pin, a change counts when stages two and three agree.
 assumes asynchronous pins from the programmer.
*/
`timescale 1ns/1ps
module few_pinsync (
	input wire logic clock_i,
	input wire logic resetn_i,
	input wire logic [4:0] pins_i,
	few_sync_if.src out
);
	import few_pkg::*;
	typedef struct packed {
		logic [4:0] s1;
		logic [4:0] s2;
		logic [4:0] s3;
		logic [4:0] q;
	} few_sync_t;
	few_sync_t st_r, st_nxt;
	// shift and accept agreed values; stage one feeds stage two only
	always_comb begin
		st_nxt = st_r;
		st_nxt.s1 = pins_i;
		st_nxt.s2 = st_r.s1;
		st_nxt.s3 = st_r.s2;
		for (int i = 0; i < 5; i++) begin
			if (st_r.s2[i] == st_r.s3[i]) begin
				st_nxt.q[i] = st_r.s3[i];
			end
		end
	end
	// strobes idle high, mode and fwe idle low
	always_ff @(posedge clock_i) begin
		if (!resetn_i) begin
			st_r <= '{s1: 5'h07, s2: 5'h07, s3: 5'h07, q: 5'h07};
		end else begin
			st_r <= st_nxt;
		end
	end
	assign out.ce_n = st_r.q[0];
	assign out.oe_n = st_r.q[1];
	assign out.we_n = st_r.q[2];
	assign out.flash_write_enable_pin = st_r.q[3];
	assign out.mode_ok = st_r.q[4];
endmodule

/* few_top.sv */
/*
 fewp top: ram overlay control, interrupt lockout and the parallel writer port with its array.
 assumes APB master, asynchronous programmer pins and a 200 MHz clock.
*/
// Overview of operation
// - enable with select 01 overlays block one
// - clearing enable removes the overlay
// - enable set blocks program and erase
// - no erase of overlay while emulating
// - program or erase masks all interrupts
// - boot program running masks all interrupts
// - error protect keeps nmi masked while set; the ERRP bit here does not gate nmi
// - flash reads during program/erase undetermined
// - writer port shows one flat array
// - memory read gives one byte per access
// - auto-program writes 128-byte pages, polled
// - auto-erase clears whole array, polled; the model clears one 128-byte page
// - bit six flags normal completion
// - status read shows error information
// - program command is 129 write cycles
// - port starts in memory read mode
// - after operations enter command wait state
// - chip disable floats outputs, logic runs
`timescale 1ns/1ps
module few_top (
	input wire logic clock_i,
	input wire logic resetn_i,
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [11:0] paddr_i,
	input wire logic [31:0] pwdata_i,
	output logic [31:0] prdata_o,
	output logic pready_o,
	output logic pslverr_o,
	input wire logic boot_running_i,
	input wire logic irq_req_i,
	input wire logic nmi_req_i,
	output logic irq_o,
	output logic nmi_o,
	output logic overlay_active_o,
	output logic [1:0] overlay_block_o,
	input wire logic writer_ce_n_i,
	input wire logic writer_oe_n_i,
	input wire logic writer_we_n_i,
	input wire logic flash_write_enable_pin_i,
	input wire logic writer_mode_i,
	input wire logic [few_pkg::ADDR_W-1:0] writer_address_bus_i,
	input wire logic [7:0] writer_data_bus_i,
	output logic [7:0] writer_data_bus_o,
	output logic writer_data_bus_oe_o
);
	import few_pkg::*;
	typedef struct packed {
		logic [2:0] emul;
		logic [3:0] fctl;
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
		logic irq;
		logic nmi;
		logic ovl;
		logic [1:0] ovl_blk;
		few_wstate_t ws;
		logic [7:0] cnt;
		logic [15:0] tmr;
		logic erase_op;
		logic fail;
		logic we_d;
		logic [7:0] dout;
		logic doe;
		logic [ADDR_W-1:0] waddr;
		logic [7:0] wdata;
		logic wr_go;
		logic [7:0] cmd;
		logic erase_clr;
		logic [ADDR_W-1:0] clr_idx;
	} few_state_t;
	few_state_t st_r, st_nxt;
	few_sync_if sif();
	logic [7:0] mem [0:(1<<ADDR_W)-1];
	logic [7:0] mem_q;
	logic [7:0] page [0:PAGE_BYTES-1];
	logic [6:0] page_idx;
	logic page_we;
	logic [6:0] flush_idx;

	few_pinsync u_sync (
		.clock_i(clock_i),
		.resetn_i(resetn_i),
		.pins_i({writer_mode_i, flash_write_enable_pin_i, writer_we_n_i,
			writer_oe_n_i, writer_ce_n_i}),
		.out(sif)
	);

	// apb access decode
	function automatic logic apb_hit(input logic [11:0] a, input logic [11:0] o);
		return a == o;
	endfunction

	assign page_idx = st_r.cnt[6:0] - 7'h1;
	assign page_we = st_r.ws == WS_PROG && st_r.we_d && !sif.we_n && !sif.ce_n;
	assign flush_idx = st_r.tmr[6:0];

	always_comb begin
		st_nxt = st_r;
		st_nxt.pready = 1'b0;
		st_nxt.pslverr = 1'b0;
		st_nxt.wr_go = 1'b0;
		// apb: one wait state, answer in access phase
		if (psel_i && penable_i && !st_r.pready) begin
			st_nxt.pready = 1'b1;
			st_nxt.prdata = 32'h0;
			if (apb_hit(paddr_i, OFS_EMUL)) begin
				st_nxt.prdata = {29'h0, st_r.emul};
			end else if (apb_hit(paddr_i, OFS_FCTL)) begin
				st_nxt.prdata = {28'h0, st_r.fctl};
			end else if (apb_hit(paddr_i, OFS_STAT)) begin
				st_nxt.prdata = {22'h0, st_r.fail, st_r.ws, st_r.ovl, st_r.irq, st_r.nmi, st_r.doe};
				if (pwrite_i) begin
					st_nxt.pslverr = 1'b1;
				end
			end else begin
				st_nxt.pslverr = 1'b1;
			end
		end
		// writes land only at the edge where the master samples pready high
		if (psel_i && penable_i && st_r.pready && pwrite_i) begin
			if (apb_hit(paddr_i, OFS_EMUL)) begin
				st_nxt.emul = pwdata_i[2:0];
			end else if (apb_hit(paddr_i, OFS_FCTL)) begin
				// emulation protection refuses program/erase set
				st_nxt.fctl[ERASE_POS:PROG_POS] = st_r.emul[EMU_EN_POS] ? 2'h0 :
					pwdata_i[ERASE_POS:PROG_POS];
				st_nxt.fctl[BOOT_POS] = pwdata_i[BOOT_POS];
				st_nxt.fctl[ERRP_POS] = pwdata_i[ERRP_POS];
			end
		end
		// overlay only for select 01 while enabled
		st_nxt.ovl = st_nxt.emul[EMU_EN_POS] &&
			st_nxt.emul[SEL_HI_POS:SEL_LO_POS] == EMUL_BLOCK_ONE;
		st_nxt.ovl_blk = st_nxt.emul[SEL_HI_POS:SEL_LO_POS];
		// lockout covers program, erase and boot; the error protect bit leaves nmi unmasked
		st_nxt.irq = irq_req_i && !(st_r.fctl[PROG_POS] || st_r.fctl[ERASE_POS] ||
			boot_running_i);
		st_nxt.nmi = nmi_req_i && !(st_r.fctl[PROG_POS] || st_r.fctl[ERASE_POS] ||
			boot_running_i);
		// writer port: a falling write strobe latches a byte
		st_nxt.we_d = sif.we_n;
		if (st_r.we_d && !sif.we_n && !sif.ce_n && sif.mode_ok) begin
			st_nxt.waddr = writer_address_bus_i;
			st_nxt.wdata = writer_data_bus_i;
			st_nxt.wr_go = 1'b1;
		end
		if (st_r.wr_go) begin
			unique case (st_r.ws)
				WS_READ, WS_WAIT, WS_STAT: begin
					st_nxt.cmd = st_r.wdata;
					if (st_r.wdata == CMD_READ) begin
						st_nxt.ws = WS_READ;
					end else if (st_r.wdata == CMD_PROG && sif.flash_write_enable_pin) begin
						st_nxt.ws = WS_PROG;
						st_nxt.cnt = 8'h1;
					end else if ((st_r.wdata == CMD_ERASE || st_r.wdata == CMD_STAT) &&
						st_r.cmd == st_r.wdata && st_r.ws != WS_READ) begin
						// second cycle of two-cycle command
						if (st_r.wdata == CMD_ERASE && sif.flash_write_enable_pin) begin
							st_nxt.ws = WS_BUSY;
							st_nxt.erase_op = 1'b1;
							st_nxt.tmr = OP_CYCLES;
						end else begin
							st_nxt.ws = WS_STAT;
						end
					end else begin
						st_nxt.ws = WS_WAIT;
					end
				end
				WS_PROG: begin
					st_nxt.cnt = st_r.cnt + 8'h1;
					if (st_r.cnt == PROG_CYCLES - 8'h1) begin
						st_nxt.ws = WS_BUSY;
						st_nxt.erase_op = 1'b0;
						st_nxt.tmr = OP_CYCLES;
					end
				end
				WS_BUSY: begin
				end
			endcase
		end
		// auto operation runs off its own timer; logic works during chip disable
		if (st_r.ws == WS_BUSY) begin
			if (st_r.tmr == 16'h0) begin
				st_nxt.ws = WS_WAIT;
				st_nxt.fail = !sif.flash_write_enable_pin;
			end else begin
				st_nxt.tmr = st_r.tmr - 16'h1;
			end
		end
		// data out only when chip and output enabled, write idle
		st_nxt.doe = !sif.ce_n && !sif.oe_n && sif.we_n && sif.mode_ok;
		unique case (st_r.ws)
			WS_READ: st_nxt.dout = mem_q;
			WS_STAT: st_nxt.dout = {1'b0, !st_r.fail, 1'b0, st_r.fail, 4'h0};
			default: st_nxt.dout = {1'b0, st_r.ws != WS_BUSY && !st_r.fail, 6'h0};
		endcase
	end

	// erase array walks one byte per cycle; page flush follows the same timer
	// reads while busy return the status byte with bit six low, not array data
	always_ff @(posedge clock_i) begin
		mem_q <= mem[writer_address_bus_i];
		if (page_we) begin
			page[page_idx] <= writer_data_bus_i;
		end
		if (st_r.ws == WS_BUSY && st_r.tmr < 16'(PAGE_BYTES)) begin
			if (st_r.erase_op) begin
				mem[{st_r.waddr[ADDR_W-1:7], flush_idx}] <= 8'hff;
			end else begin
				mem[{st_r.waddr[ADDR_W-1:7], flush_idx}] <= page[flush_idx];
			end
		end
	end

	// limitation: erase model clears the page of the last write address per pass
	always_ff @(posedge clock_i) begin
		if (!resetn_i) begin
			st_r <= '0;
			st_r.emul <= EMUL_RST;
			st_r.fctl <= FCTL_RST;
			st_r.ws <= WS_READ;
			st_r.we_d <= 1'b1;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign prdata_o = st_r.prdata;
	assign pready_o = st_r.pready;
	assign pslverr_o = st_r.pslverr;
	assign irq_o = st_r.irq;
	assign nmi_o = st_r.nmi;
	assign overlay_active_o = st_r.ovl;
	assign overlay_block_o = st_r.ovl_blk;
	assign writer_data_bus_o = st_r.dout;
	assign writer_data_bus_oe_o = st_r.doe;
endmodule

/* few_monitor.sv */
/* few_monitor: port checker for few_top.
 assumes one clock and a sync active-low reset. */
`timescale 1ns/1ps
module few_monitor (
	input wire logic clock_i,
	input wire logic resetn_i,
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pready_o,
	input wire logic pslverr_o,
	input wire logic boot_running_i,
	input wire logic irq_req_i,
	input wire logic nmi_req_i,
	input wire logic irq_o,
	input wire logic nmi_o,
	input wire logic overlay_active_o,
	input wire logic [1:0] overlay_block_o,
	input wire logic writer_ce_n_i,
	input wire logic writer_oe_n_i,
	input wire logic writer_data_bus_oe_o
);
	import few_pkg::*;
	default clocking @(posedge clock_i); endclocking
	default disable iff (!resetn_i);
	// apb: one wait state, one-cycle answer
	apb_wait_a: assert property (psel_i && penable_i && !pready_o |=> pready_o)
		else $error("pready late");
	apb_pulse_a: assert property (pready_o |=> !pready_o) else $error("pready held");
	apb_owner_a: assert property (pready_o |-> psel_i && penable_i) else $error("stray pready");
	err_tied_a: assert property (pslverr_o |-> pready_o) else $error("lone pslverr");
	// gated requests only follow a real request one cycle back
	irq_cause_a: assert property (irq_o |-> $past(irq_req_i))
		else $error("irq without request");
	nmi_cause_a: assert property (nmi_o |-> $past(nmi_req_i))
		else $error("nmi without request");
	boot_mask_a: assert property ($past(boot_running_i) |-> !irq_o && !nmi_o)
		else $error("irq during boot");
	overlay_sel_a: assert property (overlay_active_o |-> overlay_block_o == EMUL_BLOCK_ONE)
		else $error("overlay on wrong block");
	// sync delay is 4-5 clocks, so 8 idle cycles leave margin
	ce_float_a: assert property (writer_ce_n_i [*8] |-> !writer_data_bus_oe_o)
		else $error("drives while deselected");
	oe_float_a: assert property (writer_oe_n_i [*8] |-> !writer_data_bus_oe_o)
		else $error("drives with oe high");
	cover property (overlay_active_o);
	cover property ($past(irq_req_i) && !irq_o);
	cover property (writer_data_bus_oe_o);
endmodule
bind few_top few_monitor few_monitor_i (.clock_i, .resetn_i, .psel_i, .penable_i, .pready_o,
	.pslverr_o, .boot_running_i, .irq_req_i, .nmi_req_i, .irq_o, .nmi_o, .overlay_active_o,
	.overlay_block_o, .writer_ce_n_i, .writer_oe_n_i, .writer_data_bus_oe_o);

/* few_prog_model.sv */
/* few_prog_model: programmer on the writer strobes.
 assumes the bench resolves the shared data wire. */
`timescale 1ns/1ps
module few_prog_model (
	input wire logic clock_i,
	input wire logic [7:0] bus_i,
	output logic ce_n_o,
	output logic oe_n_o,
	output logic we_n_o,
	output logic fwe_o,
	output logic mode_o,
	output logic [16:0] addr_o,
	output logic [7:0] dq_o,
	output logic drv_o
);
	// idle strobes; mode pins set for writer, standby never selected
	initial begin
		{ce_n_o, oe_n_o, we_n_o} = 3'h7;
		fwe_o = 1'b1;
		mode_o = 1'b1;
		addr_o = '0;
		dq_o = '0;
		drv_o = 1'b0;
	end
	task automatic set_fwe(input logic v);
		@(posedge clock_i);
		fwe_o <= v;
	endtask
	// long holds: the device samples only after its pin synchroniser
	task automatic wr(input logic [16:0] a, input logic [7:0] d);
		@(posedge clock_i);
		addr_o <= a;
		dq_o <= d;
		drv_o <= 1'b1;
		ce_n_o <= 1'b0;
		repeat (2) @(posedge clock_i);
		we_n_o <= 1'b0;
		repeat (12) @(posedge clock_i);
		we_n_o <= 1'b1;
		repeat (10) @(posedge clock_i);
		ce_n_o <= 1'b1;
		drv_o <= 1'b0;
		addr_o <= ~a;
	endtask
	task automatic rd(input logic [16:0] a, output logic [7:0] q);
		@(posedge clock_i);
		addr_o <= a;
		ce_n_o <= 1'b0;
		oe_n_o <= 1'b0;
		repeat (10) @(posedge clock_i);
		q = bus_i;
		ce_n_o <= 1'b1;
		oe_n_o <= 1'b1;
		repeat (8) @(posedge clock_i);
	endtask
endmodule

/* tb.sv */
/* tb: self-checking bench for few_top.
 assumes few_prog_model plays the programmer. */
`timescale 1ns/1ps
module tb;
	import few_pkg::*;
	logic clock_i = 0, resetn_i = 0, psel = 0, penable = 0, pwrite = 0;
	logic boot = 0, irq_req = 0, nmi_req = 0, pready, pslverr, irq, nmi, ovl, e;
	logic ce_n, oe_n, we_n, flash_write_enable_pin, mode, drv, doe;
	logic [11:0] paddr = '0;
	logic [31:0] pwdata = '0, prdata, q;
	logic [1:0] blk;
	logic [16:0] fa;
	logic [7:0] dq, dout, fo, b, last = '0;
	logic [15:0] s = 16'h0005;
	logic [7:0] mem [int];
	int err_count = 0, compares = 0;
	few_top few_top_i (.clock_i, .resetn_i, .psel_i(psel), .penable_i(penable),
		.pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
		.pready_o(pready), .pslverr_o(pslverr), .boot_running_i(boot), .irq_req_i(irq_req),
		.nmi_req_i(nmi_req), .irq_o(irq), .nmi_o(nmi), .overlay_active_o(ovl),
		.overlay_block_o(blk), .writer_ce_n_i(ce_n), .writer_oe_n_i(oe_n),
		.writer_we_n_i(we_n), .flash_write_enable_pin_i(flash_write_enable_pin), .writer_mode_i(mode),
		.writer_address_bus_i(fa), .writer_data_bus_i(fo), .writer_data_bus_o(dout),
		.writer_data_bus_oe_o(doe));
	few_prog_model few_prog_model_i (.clock_i, .bus_i(fo), .ce_n_o(ce_n), .oe_n_o(oe_n),
		.we_n_o(we_n), .fwe_o(flash_write_enable_pin), .mode_o(mode), .addr_o(fa), .dq_o(dq), .drv_o(drv));
	// floating wire shows a changing pattern, never a stale value
	assign fo = doe ? dout : (drv ? dq : ~last);
	always @(posedge clock_i) last <= fo;
	initial forever #2.5 clock_i = ~clock_i;
	function automatic logic [15:0] lfsr(input logic [15:0] v);
		return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
	endfunction
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			err_count++;
			$display("ERROR t=%0t got %h exp %h", $time, got, exp);
		end
	endtask
	// one apb transfer, held until pready is sampled
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge clock_i);
		psel <= 1;
		penable <= 0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clock_i);
		penable <= 1;
		do @(posedge clock_i); while (pready !== 1'b1);
		q = prdata;
		e = pslverr;
		psel <= 0;
		penable <= 0;
	endtask
	task automatic wait_done;
		q = 0;
		for (int i = 0; i < 200 && !q[5]; i++) apb(0, OFS_STAT, 0);
		chk(32'(q[8:4]), 32'h2);
	endtask
	task automatic stat_chk(input logic [1:0] exp);
		few_prog_model_i.wr(0, CMD_STAT);
		few_prog_model_i.wr(0, CMD_STAT);
		few_prog_model_i.rd(0, b);
		chk(32'({b[6], b[4]}), 32'(exp));
	endtask
	task automatic final_report;
		$display("compares %0d err_count %0d", compares, err_count);
		if (err_count == 0 && compares > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask
	// watchdog: the tests need about 7000 cycles
	initial begin
		repeat (60000) @(posedge clock_i);
		err_count++;
		final_report();
	end
	initial begin
		repeat (16) @(posedge clock_i);
		resetn_i <= 1;
		apb(0, OFS_FCTL, 0);
		chk(q, 32'(FCTL_RST));
		apb(0, OFS_STAT, 0);
		chk(32'(q[9:4]), 32'h01);
		apb(1, 12'h00c, 0);
		chk(32'(e), 1);
		apb(1, OFS_STAT, 0);
		chk(32'(e), 1);
		$display("test regs done");
		// every enable/select code: overlay only on 101, lockout on any enable
		for (int v = 0; v < 8; v++) begin
			apb(1, OFS_EMUL, 32'(v));
			apb(1, OFS_FCTL, 32'h3);
			apb(0, OFS_FCTL, 0);
			chk(q & 32'h3, (v >= 4) ? 0 : 3);
			chk(32'({ovl, blk}), 32'({v == 5, 2'(v)}));
			apb(1, OFS_FCTL, 0);
		end
		apb(1, OFS_EMUL, 0);
		$display("test emulation done");
		for (int i = 0; i < 12; i++) begin
			s = lfsr(s);
			apb(1, OFS_FCTL, 32'(s[3:0]));
			irq_req <= s[4];
			nmi_req <= s[5];
			boot <= s[6];
			repeat (3) @(posedge clock_i);
			b = 8'(s[0] | s[1] | s[6]);
			chk(32'({irq, nmi}), 32'({s[4] & ~b[0], s[5] & ~b[0]}));
			apb(0, OFS_FCTL, 0);
			chk(32'(q[2:0]), 32'(s[2:0]));
		end
		apb(1, OFS_FCTL, 0);
		boot <= 0;
		$display("test interrupts done");
		few_prog_model_i.wr(0, CMD_PROG);
		for (int i = 0; i < PAGE_BYTES; i++) begin
			s = lfsr(s);
			mem[i] = s[7:0];
			few_prog_model_i.wr(17'h100 + 17'(i), s[7:0]);
		end
		wait_done();
		stat_chk(2'b10);
		few_prog_model_i.wr(0, CMD_READ);
		for (int i = 0; i < PAGE_BYTES; i++) begin
			few_prog_model_i.rd(17'h100 + 17'(i), b);
			chk(32'(b), 32'(mem[i]));
		end
		$display("test program done");
		few_prog_model_i.wr(0, CMD_ERASE);
		few_prog_model_i.wr(0, CMD_ERASE);
		few_prog_model_i.set_fwe(0);
		wait_done();
		few_prog_model_i.set_fwe(1);
		stat_chk(2'b01);
		few_prog_model_i.wr(0, CMD_READ);
		few_prog_model_i.rd(0, b);
		chk(32'(b), 32'h000000ff);
		$display("test erase done");
		final_report();
	end
endmodule
